/* File: ilsw_pkg.sv */
// Purpose: shared constants for the in-band loop switching control
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes: register indices are word indices, byte address is four times
package ilsw_pkg;
  // register word indices
  localparam logic [7:0] IDX_DETECT_TIME = 8'hd7;
  localparam logic [7:0] IDX_AUTO_SW = 8'hd9;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hdc;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hdd;
  localparam logic [7:0] IDX_LOOP_STAT = 8'hde;
  // reset values
  localparam logic [7:0] RST_DETECT_TIME = 8'h00;
  localparam logic [7:0] RST_AUTO_SW = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h0f;
  // field positions
  localparam int LINE_TIME_LSB = 4;
  localparam int FRAMER_TIME_LSB = 0;
  localparam int SW_FRAMER_BIT = 1;
  localparam int SW_LINE_BIT = 0;
  localparam logic [7:0] DETECT_TIME_MASK = 8'h33;
  localparam logic [7:0] AUTO_SW_MASK = 8'h03;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h0f;
  // status bits
  localparam int EV_LINE_UP = 0;
  localparam int EV_LINE_DOWN = 1;
  localparam int EV_FRAMER_UP = 2;
  localparam int EV_FRAMER_DOWN = 3;
  localparam int LOOP_REMOTE_BIT = 0;
  localparam int LOOP_LOCAL_BIT = 1;
  // detection time settings
  localparam logic [1:0] SEL_CNT_A = 2'h0;
  localparam logic [1:0] SEL_CNT_B = 2'h1;
  localparam logic [1:0] SEL_TIME_A = 2'h2;
  localparam logic [1:0] SEL_TIME_B = 2'h3;
  localparam int PATTERN_CNT_A = 16;
  localparam int PATTERN_CNT_B = 32;
  localparam int TIME_A_S = 4;
  localparam int TIME_B_S = 5;
  localparam int CLK_HZ = 10000000;
  localparam int TIME_A_CYC = TIME_A_S * CLK_HZ;
  localparam int TIME_B_CYC = TIME_B_S * CLK_HZ;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // qualifier states, gray along idle-run-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DONE = 2'h3
  } ilsw_qstate_t;
endpackage : ilsw_pkg

/* File: ilsw_ifs.sv */
// Purpose: carriers between the control core and its helpers
// Assumes: all signals on aclk
// Notes: reg carrier is decoded access, det carrier one qualifier
interface ilsw_reg_if #(parameter int AW = 12);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : ilsw_reg_if

interface ilsw_det_if;
  logic strobe;
  logic valid;
  logic up;
  logic [1:0] sel;
  logic det;
  logic det_up;
  modport qual (input strobe, valid, up, sel, output det, det_up);
  modport core (output strobe, valid, up, sel, input det, det_up);
endinterface : ilsw_det_if

/* File: ilsw_axil.sv */
// Purpose: axi4-lite slave turning bus transfers into register accesses
// Assumes: core answers rd_data, rd_err, wr_err combinationally
// Notes: one write and one read in flight; b and r from flops
module ilsw_axil #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded access
  ilsw_reg_if.slv bus
);
  logic awready_q;
  logic wready_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic fire_w;

  assign fire_w = !awready_q && !wready_q && !bvalid_q;
  assign bus.wr_en = fire_w;
  assign bus.wr_addr = awaddr_q;
  assign bus.wr_data = wdata_q;
  assign bus.wr_strb = wstrb_q;
  assign bus.rd_en = s_axi_arvalid && arready_q;
  assign bus.rd_addr = s_axi_araddr;

  // write address and data slots, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end else if (fire_w) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (fire_w) begin
        wready_q <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ilsw_pkg::RESP_OKAY;
    end else if (fire_w) begin
      bvalid_q <= 1'b1;
      bresp_q <= bus.wr_err ? ilsw_pkg::RESP_SLVERR : ilsw_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= ilsw_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= bus.rd_data;
      rresp_q <= bus.rd_err ? ilsw_pkg::RESP_SLVERR : ilsw_pkg::RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
endmodule : ilsw_axil

/* File: ilsw_qual.sv */
// Purpose: qualifies one side's loop code until the chosen threshold
// Assumes: strobe marks each received pattern, valid is a level
// Notes: det pulses once per uninterrupted run
module ilsw_qual #(
  parameter int CW = 26,
  parameter int TA_CYC = ilsw_pkg::TIME_A_CYC,
  parameter int TB_CYC = ilsw_pkg::TIME_B_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pattern in, detection out
  ilsw_det_if.qual d
);
  ilsw_pkg::ilsw_qstate_t st_q;
  logic [CW-1:0] cnt_q;
  logic up_q;
  logic det_q;
  logic tick;
  logic broken;
  logic hit;
  logic [CW-1:0] target;

  // count modes step per pattern, time modes per clock
  always_comb begin
    case (d.sel)
      ilsw_pkg::SEL_CNT_A: target = CW'(ilsw_pkg::PATTERN_CNT_A);
      ilsw_pkg::SEL_CNT_B: target = CW'(ilsw_pkg::PATTERN_CNT_B);
      ilsw_pkg::SEL_TIME_A: target = CW'(TA_CYC);
      default: target = CW'(TB_CYC);
    endcase
  end

  assign tick = d.sel[1] ? 1'b1 : d.strobe;
  assign broken = !d.valid || (d.up != up_q);
  assign hit = (st_q == ilsw_pkg::ST_RUN) && !broken && tick
               && (cnt_q == target - CW'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ilsw_pkg::ST_IDLE;
      cnt_q <= '0;
      up_q <= 1'b0;
    end else begin
      case (st_q)
        ilsw_pkg::ST_IDLE: begin
          if (d.valid) begin
            st_q <= ilsw_pkg::ST_RUN;
            up_q <= d.up;
            cnt_q <= tick ? CW'(1) : '0; // R1 R2 R3 R4
          end
        end
        ilsw_pkg::ST_RUN: begin
          if (broken) begin
            st_q <= ilsw_pkg::ST_IDLE; // R10
            cnt_q <= '0;
          end else if (tick) begin
            if (hit) begin
              st_q <= ilsw_pkg::ST_DONE;
            end
            cnt_q <= cnt_q + CW'(1); // R1 R2 R3 R4
          end
        end
        ilsw_pkg::ST_DONE: begin
          if (broken) begin
            st_q <= ilsw_pkg::ST_IDLE; // R10
            cnt_q <= '0;
          end
        end
        default: st_q <= ilsw_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_q <= 1'b0;
    end else begin
      det_q <= hit;
    end
  end

  assign d.det = det_q;
  assign d.det_up = up_q;
endmodule : ilsw_qual

/* File: ilsw_top.sv */
// Purpose: automatic loop switching from in-band loop codes, one port
// Assumes: pattern detectors and loop datapath run on aclk
// Notes: registers over axi4-lite, one word per register
// How it works
// R1: line side codes 00 and 01 need 16 or 32 consecutive valid patterns.
// R2: line side codes 10 and 11 need 4 s or 5 s of valid pattern.
// R3: framer side codes 00 and 01 need 16 or 32 consecutive sequences.
// R4: framer side codes 10 and 11 need 4 s or 5 s of valid sequence.
// R5: framer enable bit 1 lets framer codes close and open local loop.
// R6: line enable bit 0 lets line codes close and open remote loop.
// R7: remote switching only acts while local loop select is clear.
// R8: software never sets both switching enables at once.
// R9: loop up and down detections raise interrupt unless masked.
// R10: any break in the pattern restarts count or timer.
module ilsw_top #(
  parameter int AW = 12,
  parameter int CW = 26,
  parameter int TA_CYC = ilsw_pkg::TIME_A_CYC,
  parameter int TB_CYC = ilsw_pkg::TIME_B_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line side code detector
  input wire logic line_pat_strobe,
  input wire logic line_pat_valid,
  input wire logic line_pat_up,
  // framer side code detector
  input wire logic framer_pat_strobe,
  input wire logic framer_pat_valid,
  input wire logic framer_pat_up,
  // manual local loop
  input wire logic local_loop_select,
  // loop controls
  output logic remote_loop_q,
  output logic local_loop_q,
  // interrupt
  output logic irq_q
);
  localparam int IDX_W = AW - 2;

  ilsw_reg_if #(.AW(AW)) bus ();
  ilsw_det_if line_det ();
  ilsw_det_if framer_det ();

  logic [7:0] loop_detect_time_cfg_q;
  logic [7:0] auto_loop_switch_cfg_q;
  logic [7:0] interrupt_mask_six_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_set;
  logic [7:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic wr_lane;
  logic line_switch_ok;
  logic framer_switch_ok;

  // refuse sizes the logic cannot serve
  initial begin
    if (AW < 10 || AW > 32) begin
      $error("address width out of range");
    end
    if (CW < 6 || CW > 31) begin
      $error("counter width out of range");
    end
    if (TA_CYC < ilsw_pkg::PATTERN_CNT_B || TB_CYC < TA_CYC) begin
      $error("time thresholds out of order");
    end
    if (longint'(TB_CYC) >= (longint'(1) << CW)) begin
      $error("counter too narrow for time threshold");
    end
  end

  // word index match for an aligned access
  function automatic logic idx_is(input logic [AW-1:0] a, input logic [7:0] idx);
    idx_is = (a[1:0] == 2'h0) && (a[AW-1:2] == IDX_W'(idx));
  endfunction : idx_is

  ilsw_axil #(
    .AW(AW)
  ) u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(bus.slv)
  );

  // detector hookup, thresholds from the time register
  assign line_det.strobe = line_pat_strobe;
  assign line_det.valid = line_pat_valid;
  assign line_det.up = line_pat_up;
  assign line_det.sel = loop_detect_time_cfg_q[ilsw_pkg::LINE_TIME_LSB +: 2]; // R1 R2
  assign framer_det.strobe = framer_pat_strobe;
  assign framer_det.valid = framer_pat_valid;
  assign framer_det.up = framer_pat_up;
  assign framer_det.sel = loop_detect_time_cfg_q[ilsw_pkg::FRAMER_TIME_LSB +: 2]; // R3 R4

  ilsw_qual #(
    .CW(CW),
    .TA_CYC(TA_CYC),
    .TB_CYC(TB_CYC)
  ) u_line_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(line_det.qual)
  );

  ilsw_qual #(
    .CW(CW),
    .TA_CYC(TA_CYC),
    .TB_CYC(TB_CYC)
  ) u_framer_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(framer_det.qual)
  );

  // write decode, only the low byte lane carries register bits
  assign wr_lane = bus.wr_strb[0];
  assign wr_hit = idx_is(bus.wr_addr, ilsw_pkg::IDX_DETECT_TIME)
                  || idx_is(bus.wr_addr, ilsw_pkg::IDX_AUTO_SW)
                  || idx_is(bus.wr_addr, ilsw_pkg::IDX_IRQ_MASK)
                  || idx_is(bus.wr_addr, ilsw_pkg::IDX_IRQ_STAT)
                  || idx_is(bus.wr_addr, ilsw_pkg::IDX_LOOP_STAT);
  assign bus.wr_err = !wr_hit;

  // detection time register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_detect_time_cfg_q <= ilsw_pkg::RST_DETECT_TIME;
    end else if (bus.wr_en && wr_lane && idx_is(bus.wr_addr, ilsw_pkg::IDX_DETECT_TIME)) begin
      loop_detect_time_cfg_q <= bus.wr_data[7:0] & ilsw_pkg::DETECT_TIME_MASK;
    end
  end

  // switching enables, both set is left to software to avoid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_loop_switch_cfg_q <= ilsw_pkg::RST_AUTO_SW; // R5 R6
    end else if (bus.wr_en && wr_lane && idx_is(bus.wr_addr, ilsw_pkg::IDX_AUTO_SW)) begin
      auto_loop_switch_cfg_q <= bus.wr_data[7:0] & ilsw_pkg::AUTO_SW_MASK; // R8
    end
  end

  // interrupt mask, a set bit blocks its event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_mask_six_q <= ilsw_pkg::RST_IRQ_MASK;
    end else if (bus.wr_en && wr_lane && idx_is(bus.wr_addr, ilsw_pkg::IDX_IRQ_MASK)) begin
      interrupt_mask_six_q <= bus.wr_data[7:0] & ilsw_pkg::IRQ_BITS_MASK;
    end
  end

  // loop events
  always_comb begin
    irq_set = '0;
    irq_set[ilsw_pkg::EV_LINE_UP] = line_det.det && line_det.det_up; // R9
    irq_set[ilsw_pkg::EV_LINE_DOWN] = line_det.det && !line_det.det_up; // R9
    irq_set[ilsw_pkg::EV_FRAMER_UP] = framer_det.det && framer_det.det_up; // R9
    irq_set[ilsw_pkg::EV_FRAMER_DOWN] = framer_det.det && !framer_det.det_up; // R9
  end

  // sticky status, cleared by read, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else if (bus.rd_en && idx_is(bus.rd_addr, ilsw_pkg::IDX_IRQ_STAT)) begin
      irq_stat_q <= irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & ~interrupt_mask_six_q); // R9
    end
  end

  // switching permissions
  assign line_switch_ok = auto_loop_switch_cfg_q[ilsw_pkg::SW_LINE_BIT]
                          && !local_loop_select; // R6 R7
  assign framer_switch_ok = auto_loop_switch_cfg_q[ilsw_pkg::SW_FRAMER_BIT]; // R5

  // remote loop follows qualified line codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_loop_q <= 1'b0;
    end else if (line_det.det && line_switch_ok) begin
      remote_loop_q <= line_det.det_up; // R6 R7
    end
  end

  // local loop follows qualified framer codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_loop_q <= 1'b0;
    end else if (framer_det.det && framer_switch_ok) begin
      local_loop_q <= framer_det.det_up; // R5
    end
  end

  // read mux
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (idx_is(bus.rd_addr, ilsw_pkg::IDX_DETECT_TIME)) begin
      rd_word = loop_detect_time_cfg_q;
    end else if (idx_is(bus.rd_addr, ilsw_pkg::IDX_AUTO_SW)) begin
      rd_word = auto_loop_switch_cfg_q;
    end else if (idx_is(bus.rd_addr, ilsw_pkg::IDX_IRQ_STAT)) begin
      rd_word = irq_stat_q;
    end else if (idx_is(bus.rd_addr, ilsw_pkg::IDX_IRQ_MASK)) begin
      rd_word = interrupt_mask_six_q;
    end else if (idx_is(bus.rd_addr, ilsw_pkg::IDX_LOOP_STAT)) begin
      rd_word[ilsw_pkg::LOOP_REMOTE_BIT] = remote_loop_q;
      rd_word[ilsw_pkg::LOOP_LOCAL_BIT] = local_loop_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign bus.rd_data = {24'h000000, rd_word};
  assign bus.rd_err = !rd_hit;
endmodule : ilsw_top

/* File: ilsw_top_assertions.sv */
// Purpose: port level checks of loop switching and register bus answers
// Assumes: one clock, synchronous active-low reset, one strobe per valid cycle
// Notes: run counters restart when valid drops or the code direction changes
module ilsw_top_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // code detectors
  input wire logic line_pat_valid,
  input wire logic line_pat_up,
  input wire logic framer_pat_valid,
  input wire logic framer_pat_up,
  input wire logic local_loop_select,
  // loop controls
  input wire logic remote_loop_q,
  input wire logic local_loop_q
);
  logic [1:0] vld;
  logic [1:0] up_s;
  logic [1:0] up_q;
  logic [7:0] run_q [2];
  assign vld = {framer_pat_valid, line_pat_valid};
  assign up_s = {framer_pat_up, line_pat_up};
  // uninterrupted run length per side
  always_ff @(posedge aclk) begin
    up_q <= up_s;
    for (int i = 0; i < 2; i++) begin
      if (!aresetn || !vld[i]) run_q[i] <= 8'h00;
      else if (run_q[i] == 8'h00 || up_s[i] != up_q[i]) run_q[i] <= 8'h01;
      else if (run_q[i] != 8'hff) run_q[i] <= run_q[i] + 8'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  remote_close_a: assert property ($rose(remote_loop_q) |->
    $past(run_q[0]) >= 8'h10 && $past(line_pat_up, 2)) else $error("remote loop closed early");
  remote_open_a: assert property ($fell(remote_loop_q) |->
    $past(run_q[0]) >= 8'h10 && !$past(line_pat_up, 2)) else $error("remote loop opened early");
  remote_block_a: assert property ($rose(remote_loop_q) |-> !$past(local_loop_select))
    else $error("remote loop closed while local loop selected");
  local_close_a: assert property ($rose(local_loop_q) |->
    $past(run_q[1]) >= 8'h10 && $past(framer_pat_up, 2)) else $error("local loop closed early");
  local_open_a: assert property ($fell(local_loop_q) |->
    $past(run_q[1]) >= 8'h10 && !$past(framer_pat_up, 2)) else $error("local loop opened early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not offered after address taken");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped before taken");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write response late");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
endmodule : ilsw_top_assertions

bind ilsw_top ilsw_top_assertions i_ilsw_top_assertions (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .line_pat_valid, .line_pat_up,
  .framer_pat_valid, .framer_pat_up, .local_loop_select, .remote_loop_q, .local_loop_q);

/* File: test_ilsw_top.sv */
// Purpose: register and loop switching tests of the control block
// Assumes: short validity times of 40 and 50 cycles
// Notes: one strobe per valid cycle, idle gap ends every run
module test_ilsw_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK = ilsw_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ilsw_pkg::RESP_SLVERR;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic line_pat_strobe, line_pat_valid, line_pat_up;
  logic framer_pat_strobe, framer_pat_valid, framer_pat_up;
  logic local_loop_select, remote_loop_q, local_loop_q, irq_q;
  int errors, tests_run, cycles;
  int thr [4] = '{16, 32, 40, 50};

  ilsw_top #(.TA_CYC(40), .TB_CYC(50)) i_ilsw_top (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_pat_strobe, .line_pat_valid,
    .line_pat_up, .framer_pat_strobe, .framer_pat_valid, .framer_pat_up, .local_loop_select,
    .remote_loop_q, .local_loop_q, .irq_q);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
    if (er === OK) chk(rd_q, {24'h0, exp});
  endtask : rd

  task automatic pat(input logic side, input logic up, input int n);
    @(posedge aclk);
    repeat (n) begin
      line_pat_valid <= !side;
      line_pat_strobe <= !side;
      framer_pat_valid <= side;
      framer_pat_strobe <= side;
      line_pat_up <= up;
      framer_pat_up <= up;
      @(posedge aclk);
    end
    {line_pat_valid, line_pat_strobe, framer_pat_valid, framer_pat_strobe} <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask : pat

  initial begin
    errors = 0;
    tests_run = 0;
    cycles = 0;
    aresetn = 1'b0;
    s_axi_wstrb = 4'hf;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {line_pat_strobe, line_pat_valid, line_pat_up, local_loop_select} = '0;
    {framer_pat_strobe, framer_pat_valid, framer_pat_up} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, reserved bits, bad addresses
    rd(ilsw_pkg::IDX_DETECT_TIME, 8'h00, OK);
    rd(ilsw_pkg::IDX_AUTO_SW, 8'h00, OK);
    rd(ilsw_pkg::IDX_IRQ_MASK, 8'h0f, OK);
    rd(ilsw_pkg::IDX_IRQ_STAT, 8'h00, OK);
    rd(ilsw_pkg::IDX_LOOP_STAT, 8'h00, OK);
    rd(8'he0, 8'h00, ERR);
    wr(8'he0, 8'h55, ERR);
    wr(ilsw_pkg::IDX_LOOP_STAT, 8'h03, OK);
    rd(ilsw_pkg::IDX_LOOP_STAT, 8'h00, OK);
    wr(ilsw_pkg::IDX_DETECT_TIME, 8'hff, OK);
    rd(ilsw_pkg::IDX_DETECT_TIME, 8'h33, OK);
    // low byte lane off, write ignored
    s_axi_wstrb <= 4'he;
    wr(ilsw_pkg::IDX_DETECT_TIME, 8'h00, OK);
    s_axi_wstrb <= 4'hf;
    rd(ilsw_pkg::IDX_DETECT_TIME, 8'h33, OK);
    chk(32'(irq_q), 32'h0);
    // every threshold code on both sides
    for (int s = 0; s < 2; s++) begin
      wr(ilsw_pkg::IDX_AUTO_SW, s ? 8'h02 : 8'h01, OK);
      for (int m = 0; m < 4; m++) begin
        wr(ilsw_pkg::IDX_DETECT_TIME, 8'(s ? m : m * 16), OK);
        pat(s[0], 1'b1, thr[m] - 1);
        pat(s[0], 1'b1, thr[m] - 1);
        chk(32'({remote_loop_q, local_loop_q}), 32'h0);
        pat(s[0], 1'b1, thr[m]);
        chk(32'({remote_loop_q, local_loop_q}), s ? 32'h1 : 32'h2);
        pat(s[0], 1'b0, thr[m]);
        chk(32'({remote_loop_q, local_loop_q}), 32'h0);
        rd(ilsw_pkg::IDX_IRQ_STAT, s ? 8'h0c : 8'h03, OK);
      end
    end
    // enables off, events still flagged
    wr(ilsw_pkg::IDX_AUTO_SW, 8'h00, OK);
    wr(ilsw_pkg::IDX_DETECT_TIME, 8'h00, OK);
    pat(1'b0, 1'b1, 16);
    pat(1'b1, 1'b1, 16);
    chk(32'({remote_loop_q, local_loop_q}), 32'h0);
    rd(ilsw_pkg::IDX_IRQ_STAT, 8'h05, OK);
    // manual local loop blocks remote switching
    wr(ilsw_pkg::IDX_AUTO_SW, 8'h01, OK);
    local_loop_select <= 1'b1;
    pat(1'b0, 1'b1, 16);
    chk(32'(remote_loop_q), 32'h0);
    local_loop_select <= 1'b0;
    rd(ilsw_pkg::IDX_IRQ_STAT, 8'h01, OK);
    // interrupt mask and read clear
    wr(ilsw_pkg::IDX_IRQ_MASK, 8'h0e, OK);
    pat(1'b0, 1'b0, 16);
    chk(32'(irq_q), 32'h0);
    pat(1'b0, 1'b1, 16);
    chk(32'({irq_q, remote_loop_q}), 32'h3);
    rd(ilsw_pkg::IDX_IRQ_STAT, 8'h03, OK);
    repeat (2) @(posedge aclk);
    chk(32'(irq_q), 32'h0);
    final_report();
  end
endmodule : test_ilsw_top
